// file: rtl/seq_setup_regs.sv
// Setup and transfer registers of the disk data sequencer.
// Assumes a classic Wishbone master, a DMA controller on channel 0 and a
// sequencer core that supplies ID bytes, state advances and error events.
`timescale 1ns/1ps
// Functional notes
// - Sector size is count times multiplier plus one
// - Count byte zero means 256 bytes
// - Compare target IDs with first four header bytes
// - Head compare low nibble or full byte
// - Sector number increments after valid data field
// - Byte port write latches byte, requests DMA
// - Unanswered request sets overrun and nonzero status
// - Peripheral transfer needs transfer enable bit
// - Peripheral read pulses strobe, then DMA write
// - Start at low nibble, restart at high
// - Sixteen states, each at its RAM address
// - State repeats count; data field times multiplier plus one
// - Start/restart value addresses format RAM
// - Loop state nibble selects jump-back state
// - Bit 4 selects format RAM bank
// - Bit ring nibble sets sync offset, init 03h
// - Parity mode merges overruns, bit 1 parity
// - Abort on parity when bits 4 and 5 set
// - Abort on overrun when bit 6 set
// - Bit 7 swaps ID bytes 3 and 4
module seq_setup_regs
  import seq_setup_pkg::*;
#(
  parameter int DMA_TIMEOUT = DMA_TIMEOUT_CYC,
  parameter int STROBE_LEN = GRP_STROBE_CYC
) (
  input wire logic clk_i,             // System clock
  input wire logic rst_i,             // Synchronous reset
  input wire logic cyc_i,             // Wishbone cycle
  input wire logic stb_i,             // Wishbone strobe
  input wire logic we_i,              // Wishbone write enable
  input wire logic [9:0] adr_i,       // Wishbone byte address
  input wire logic [3:0] sel_i,       // Wishbone byte selects
  input wire logic [31:0] dat_i,      // Wishbone write data
  output logic [31:0] dat_o,          // Wishbone read data
  output logic ack_o,                 // Wishbone acknowledge
  input wire logic [7:0] periph_data_i, // Peripheral bus byte
  output logic group_read_strobe_n_o, // Peripheral read strobe
  output logic dma_ch0_request_o,     // DMA channel 0 request
  input wire logic dma_ch0_acknowledge_i, // DMA channel 0 acknowledge
  output logic buf_we_o,              // Buffer write strobe
  output logic [7:0] buf_data_o,      // Buffer write byte
  input wire logic cmd_start_i,       // Command begins
  input wire logic byte_tick_i,       // One byte time elapsed
  input wire logic id_valid_i,        // Header bytes valid
  input wire id_header_t id_disk_i,   // Header read from disk
  input wire logic data_field_done_i, // Valid data field finished
  input wire logic drive_ovun_i,      // Drive data overrun event
  input wire logic parity_err_i,      // Buffer parity error event
  output logic id_match_o,            // Header matches target
  output logic [3:0] seq_state_o,     // Current sequencer state
  output logic [7:0] state_value_o,   // Value byte of state
  output logic cmd_abort_o,           // Abort running command
  output logic [3:0] bit_ring_o       // Sync to byte clock offset
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] sector_multiplier_q;
  id_header_t target_q;
  logic [7:0] buffer_byte_port_q;
  logic [7:0] start_restart_state_q;
  logic [7:0] loop_state_bank_q;
  logic [7:0] bit_ring_parity_ctl_q;
  logic [7:0] crc_ecc_control_q;
  logic [7:0] config_control_q;
  logic [7:0] ext_status_q;
  logic [7:0] fmt_ram_q [64];
  port_state_t port_q;
  logic [15:0] port_cnt_q;
  logic [3:0] state_q;
  logic [15:0] rep_q;
  logic busy_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic id_match_q;
  logic abort_q;
  logic [7:0] value_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic [7:0] idx = adr_i[9:2];
  wire logic req = cyc_i & stb_i & ~ack_q;
  wire logic wr = req & we_i & sel_i[0];
  wire logic rd = req & ~we_i;
  wire logic wr_mult = wr & (idx == IDX_SECTOR_MULTIPLIER);
  wire logic wr_cylh = wr & (idx == IDX_TARGET_CYL_HIGH);
  wire logic wr_cyll = wr & (idx == IDX_TARGET_CYL_LOW);
  wire logic wr_head = wr & (idx == IDX_TARGET_HEAD);
  wire logic wr_sect = wr & (idx == IDX_TARGET_SECTOR);
  wire logic wr_port = wr & (idx == IDX_BUFFER_BYTE_PORT);
  wire logic wr_srs = wr & (idx == IDX_START_RESTART_STATE);
  wire logic wr_loop = wr & (idx == IDX_LOOP_STATE_BANK);
  wire logic wr_ring = wr & (idx == IDX_BIT_RING_PARITY_CTL);
  wire logic wr_crc = wr & (idx == IDX_CRC_ECC_CONTROL);
  wire logic wr_cfg = wr & (idx == IDX_CONFIG_CONTROL);
  wire logic wr_ram = wr & (idx == IDX_FMT_RAM_DATA);
  wire logic rd_ext = rd & (idx == IDX_EXTENDED_STATUS);
  wire logic rd_fetch = rd & (idx == IDX_PERIPHERAL_FETCH_READ);

  // ----------------------------------------------------------------
  // Derived controls
  // ----------------------------------------------------------------
  wire logic parity_en = bit_ring_parity_ctl_q[PARITY_EN_BIT];
  wire logic bank = loop_state_bank_q[BANK_BIT];
  // Format RAM: bank, address, byte of pair (0 value, 1 count)
  wire logic [5:0] load_addr = {bank, start_restart_state_q[3:0], dat_i[8]};
  wire logic [5:0] val_addr = {bank, state_q, 1'b0};
  wire logic [5:0] cnt_addr = {bank, state_q, 1'b1};
  wire logic [8:0] field_cnt = (fmt_ram_q[cnt_addr] == 8'h00) ? 9'd256
                               : {1'b0, fmt_ram_q[cnt_addr]};
  wire logic [8:0] mult_p1 = {1'b0, sector_multiplier_q} + 9'd1;
  wire logic [17:0] prod = field_cnt * mult_p1;
  wire logic [16:0] sector_size = prod[16:0];
  wire logic is_data_state = (state_q == start_restart_state_q[7:4]) ? 1'b0
                             : (state_q == loop_state_bank_q[3:0] - 4'd1);
  // Repeat length: count, or count times (multiplier plus one) for data field
  wire logic [15:0] rep_len = is_data_state ? sector_size[15:0] - 16'd1
                              : 16'(field_cnt - 9'd1);
  wire logic state_done = byte_tick_i & (rep_q == rep_len);
  wire logic at_loop = state_q == loop_state_bank_q[3:0];
  wire logic [3:0] next_state = at_loop ? start_restart_state_q[7:4]
                                : state_q + 4'd1;
  // ID compare with optional byte swap and head nibble mode
  wire logic swap = bit_ring_parity_ctl_q[SWAP_ID_BIT];
  wire logic [7:0] disk_b2 = swap ? id_disk_i.sector : id_disk_i.head;
  wire logic [7:0] disk_b3 = swap ? id_disk_i.head : id_disk_i.sector;
  wire logic [7:0] head_mask = config_control_q[FLAG_BYTE_MODE_BIT] ? 8'hFF
                               : 8'h0F;
  wire logic match = (id_disk_i.cyl_high == target_q.cyl_high)
                   & (id_disk_i.cyl_low == target_q.cyl_low)
                   & (((disk_b2 ^ target_q.head) & head_mask) == 8'h00)
                   & (disk_b3 == target_q.sector);
  // Overrun and parity events into extended status
  wire logic micro_ovun = (port_q == PORT_REQ) & ~dma_ch0_acknowledge_i
                          & (port_cnt_q == 16'(DMA_TIMEOUT));
  wire logic ovun_any = micro_ovun | drive_ovun_i;
  wire logic [7:0] ext_set = parity_en
    ? {6'h00, parity_err_i, ovun_any}
    : {6'h00, micro_ovun, drive_ovun_i};
  wire logic abort_ev = (ovun_any & bit_ring_parity_ctl_q[ABORT_OVUN_BIT])
    | (parity_en & parity_err_i & bit_ring_parity_ctl_q[ABORT_PARITY_BIT]);
  wire logic fetch_ok = rd_fetch & crc_ecc_control_q[XFER_ENABLE_BIT];

  // Read multiplexer
  logic [7:0] rbyte;
  always_comb begin
    unique case (idx)
      IDX_SECTOR_MULTIPLIER: rbyte = sector_multiplier_q;
      IDX_TARGET_CYL_HIGH: rbyte = target_q.cyl_high;
      IDX_TARGET_CYL_LOW: rbyte = target_q.cyl_low;
      IDX_TARGET_HEAD: rbyte = target_q.head;
      IDX_TARGET_SECTOR: rbyte = target_q.sector;
      IDX_START_RESTART_STATE: rbyte = start_restart_state_q;
      IDX_LOOP_STATE_BANK: rbyte = loop_state_bank_q;
      IDX_BIT_RING_PARITY_CTL: rbyte = bit_ring_parity_ctl_q;
      IDX_CRC_ECC_CONTROL: rbyte = crc_ecc_control_q;
      IDX_CONFIG_CONTROL: rbyte = config_control_q;
      IDX_SEQUENCER_STATUS: rbyte = {(ext_status_q != 8'h00), 7'h00};
      IDX_EXTENDED_STATUS: rbyte = ext_status_q;
      IDX_SECTOR_SIZE: rbyte = sector_size[7:0];
      IDX_SEQ_STATE: rbyte = {3'h0, busy_q, state_q};
      default: rbyte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer: registered ack one cycle after request, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      rdat_q <= {24'h00_0000, rbyte};
    end
  end

  // Software registers hold until rewritten
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sector_multiplier_q <= RST_ZERO;
      start_restart_state_q <= RST_START_RESTART;
      loop_state_bank_q <= RST_LOOP_STATE;
      bit_ring_parity_ctl_q <= RST_BIT_RING;
      crc_ecc_control_q <= RST_ZERO;
      config_control_q <= RST_ZERO;
    end else begin
      if (wr_mult) sector_multiplier_q <= dat_i[7:0];
      if (wr_srs) start_restart_state_q <= dat_i[7:0];
      if (wr_loop) loop_state_bank_q <= {3'h0, dat_i[4:0]};
      if (wr_ring) bit_ring_parity_ctl_q <= dat_i[7:0];
      if (wr_crc) crc_ecc_control_q <= dat_i[7:0];
      if (wr_cfg) config_control_q <= dat_i[7:0];
    end
  end

  // Target IDs; sector counts up after a valid data field
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_q <= '0;
    end else begin
      if (wr_cylh) target_q.cyl_high <= dat_i[7:0];
      if (wr_cyll) target_q.cyl_low <= dat_i[7:0];
      if (wr_head) target_q.head <= dat_i[7:0];
      if (wr_sect) target_q.sector <= dat_i[7:0];
      else if (data_field_done_i) target_q.sector <= target_q.sector + 8'd1;
    end
  end

  // Format RAM loading at start/restart address
  always_ff @(posedge clk_i) begin
    if (wr_ram) fmt_ram_q[load_addr] <= dat_i[7:0];
  end

  // Extended status: set wins over read-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_status_q <= RST_ZERO;
    end else if (rd_ext) begin
      ext_status_q <= ext_set;
    end else begin
      ext_status_q <= ext_status_q | ext_set;
    end
  end

  // ----------------------------------------------------------------
  // Byte port to buffer via DMA channel 0
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_q <= PORT_IDLE;
      port_cnt_q <= 16'h0000;
      buffer_byte_port_q <= RST_ZERO;
      buf_we_o <= 1'b0;
    end else begin
      buf_we_o <= 1'b0;
      unique case (port_q)
        PORT_IDLE: begin
          port_cnt_q <= 16'h0000;
          if (wr_port) begin
            buffer_byte_port_q <= dat_i[7:0];
            port_q <= PORT_REQ;
          end else if (fetch_ok) begin
            port_q <= PORT_STROBE;
          end
        end
        PORT_STROBE: begin
          port_cnt_q <= port_cnt_q + 16'h0001;
          if (port_cnt_q == 16'(STROBE_LEN - 1)) begin
            buffer_byte_port_q <= periph_data_i;
            port_cnt_q <= 16'h0000;
            port_q <= PORT_REQ;
          end
        end
        PORT_REQ: begin
          if (port_cnt_q != 16'(DMA_TIMEOUT)) port_cnt_q <= port_cnt_q + 16'h0001;
          if (dma_ch0_acknowledge_i) begin
            buf_we_o <= 1'b1;
            port_q <= PORT_IDLE;
          end
        end
        default: port_q <= PORT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State walker through the sixteen format RAM states
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= 4'h0;
      rep_q <= 16'h0000;
      busy_q <= 1'b0;
      id_match_q <= 1'b0;
      abort_q <= 1'b0;
      value_q <= RST_ZERO;
    end else begin
      abort_q <= abort_ev;
      value_q <= fmt_ram_q[val_addr];
      if (id_valid_i) id_match_q <= match;
      if (cmd_start_i) begin
        state_q <= start_restart_state_q[3:0];
        rep_q <= 16'h0000;
        busy_q <= 1'b1;
      end else if (abort_ev) begin
        busy_q <= 1'b0;
      end else if (busy_q && byte_tick_i) begin
        rep_q <= state_done ? 16'h0000 : rep_q + 16'h0001;
        if (state_done) state_q <= next_state;
      end
    end
  end

  // Output drive from flops
  assign dat_o = rdat_q;
  assign ack_o = ack_q;
  assign group_read_strobe_n_o = ~(port_q == PORT_STROBE);
  assign dma_ch0_request_o = (port_q == PORT_REQ);
  assign buf_data_o = buffer_byte_port_q;
  assign id_match_o = id_match_q;
  assign seq_state_o = state_q;
  assign state_value_o = value_q;
  assign cmd_abort_o = abort_q;
  assign bit_ring_o = bit_ring_parity_ctl_q[3:0];
endmodule : seq_setup_regs

// file: rtl/seq_setup_pkg.sv
// Package for the sequencer setup register block.
// Assumes byte-wide registers behind a classic 32-bit Wishbone slave.
package seq_setup_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SECTOR_MULTIPLIER = 8'h13;
  localparam logic [7:0] IDX_TARGET_CYL_HIGH = 8'h14;
  localparam logic [7:0] IDX_TARGET_CYL_LOW = 8'h15;
  localparam logic [7:0] IDX_TARGET_HEAD = 8'h16;
  localparam logic [7:0] IDX_TARGET_SECTOR = 8'h17;
  localparam logic [7:0] IDX_BUFFER_BYTE_PORT = 8'h18;
  localparam logic [7:0] IDX_START_RESTART_STATE = 8'h19;
  localparam logic [7:0] IDX_LOOP_STATE_BANK = 8'h1A;
  localparam logic [7:0] IDX_BIT_RING_PARITY_CTL = 8'h1B;
  // Own registers
  localparam logic [7:0] IDX_CRC_ECC_CONTROL = 8'h1C;
  localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h1D;
  localparam logic [7:0] IDX_PERIPHERAL_FETCH_READ = 8'h0F;
  localparam logic [7:0] IDX_SEQUENCER_STATUS = 8'h20;
  localparam logic [7:0] IDX_EXTENDED_STATUS = 8'h21;
  localparam logic [7:0] IDX_SECTOR_SIZE = 8'h22;
  localparam logic [7:0] IDX_FMT_RAM_DATA = 8'h23;
  localparam logic [7:0] IDX_SEQ_STATE = 8'h24;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int XFER_ENABLE_BIT = 5;   // crc_ecc_control
  localparam int FLAG_BYTE_MODE_BIT = 2; // config_control
  localparam int PARITY_EN_BIT = 4;
  localparam int ABORT_PARITY_BIT = 5;
  localparam int ABORT_OVUN_BIT = 6;
  localparam int SWAP_ID_BIT = 7;
  localparam int BANK_BIT = 4;
  localparam int EXT_NONZERO_BIT = 7;   // sequencer_status
  localparam int EXT_DRIVE_OVUN_BIT = 0;
  localparam int EXT_MICRO_OVUN_BIT = 1;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BIT_RING = 8'h03;
  localparam logic [7:0] RST_START_RESTART = 8'h33;
  localparam logic [7:0] RST_LOOP_STATE = 8'h0E;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int CLK_MHZ = 100;
  localparam int DMA_TIMEOUT_NS = 2000;
  localparam int DMA_TIMEOUT_CYC = (DMA_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int GRP_STROBE_NS = 100;
  localparam int GRP_STROBE_CYC = (GRP_STROBE_NS * CLK_MHZ + 999) / 1000;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cyl_high;
    logic [7:0] cyl_low;
    logic [7:0] head;
    logic [7:0] sector;
  } id_header_t;
  typedef enum logic [1:0] {
    PORT_IDLE = 2'b00,
    PORT_STROBE = 2'b01,
    PORT_REQ = 2'b11
  } port_state_t;
endpackage : seq_setup_pkg

// file: bench/seq_setup_regs_sva.sv
// Checker for the sequencer setup register block, ports only.
// Assumes one clock, synchronous active-high reset, bound below.
`timescale 1ns/1ps
module seq_setup_regs_sva
  import seq_setup_pkg::*;
#(
  parameter int STROBE_LEN = GRP_STROBE_CYC
) (
  input wire logic clk_i,                 // System clock
  input wire logic rst_i,                 // Synchronous reset
  input wire logic cyc_i,                 // Wishbone cycle
  input wire logic stb_i,                 // Wishbone strobe
  input wire logic we_i,                  // Wishbone write enable
  input wire logic [9:0] adr_i,           // Wishbone byte address
  input wire logic [3:0] sel_i,           // Wishbone byte selects
  input wire logic [31:0] dat_i,          // Wishbone write data
  input wire logic ack_o,                 // Wishbone acknowledge
  input wire logic group_read_strobe_n_o, // Peripheral read strobe
  input wire logic dma_ch0_request_o,     // DMA request
  input wire logic dma_ch0_acknowledge_i, // DMA acknowledge
  input wire logic buf_we_o,              // Buffer write strobe
  input wire logic cmd_start_i,           // Command begins
  input wire logic [3:0] seq_state_o,     // Sequencer state
  input wire logic [3:0] bit_ring_o       // Bit ring offset
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [7:0] low_cnt_q;
  logic [7:0] start_q;
  logic [7:0] ring_q;
  wire logic wr_take = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  wire logic [7:0] wr_idx = adr_i[9:2];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Strobe length counter and shadows of two registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt_q <= 8'h00;
      start_q <= 8'h33;
      ring_q <= 8'h03;
    end else begin
      low_cnt_q <= group_read_strobe_n_o ? 8'h00 : low_cnt_q + 8'h01;
      if (wr_take && wr_idx == IDX_START_RESTART_STATE) start_q <= dat_i[7:0];
      if (wr_take && wr_idx == IDX_BIT_RING_PARITY_CTL) ring_q <= dat_i[7:0];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  a_port_request: assert property (wr_take && wr_idx == IDX_BUFFER_BYTE_PORT
    && !dma_ch0_request_o && group_read_strobe_n_o |-> ##[1:3] dma_ch0_request_o)
    else $error("byte port write raised no DMA request");
  a_ack_writes: assert property (dma_ch0_request_o && dma_ch0_acknowledge_i
    |-> ##[0:1] buf_we_o)
    else $error("DMA acknowledge gave no buffer write");
  a_req_release: assert property (dma_ch0_request_o && dma_ch0_acknowledge_i
    |-> ##[1:2] !dma_ch0_request_o)
    else $error("DMA request not released after acknowledge");
  a_strobe_len: assert property ($rose(group_read_strobe_n_o)
    |-> low_cnt_q == 8'(STROBE_LEN))
    else $error("read strobe low for wrong number of cycles");
  a_strobe_req: assert property ($rose(group_read_strobe_n_o)
    |-> ##[0:2] dma_ch0_request_o)
    else $error("no DMA request after read strobe");
  a_start_state: assert property (cmd_start_i |=> seq_state_o == start_q[3:0])
    else $error("sequencer did not begin at start state");
  a_ring_value: assert property (!cyc_i && !$past(cyc_i, 2)
    |-> bit_ring_o == ring_q[3:0])
    else $error("bit ring output differs from written value");
endmodule : seq_setup_regs_sva
bind seq_setup_regs seq_setup_regs_sva #(.STROBE_LEN(STROBE_LEN)) seq_setup_regs_sva_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
  .group_read_strobe_n_o(group_read_strobe_n_o), .dma_ch0_request_o(dma_ch0_request_o),
  .dma_ch0_acknowledge_i(dma_ch0_acknowledge_i), .buf_we_o(buf_we_o),
  .cmd_start_i(cmd_start_i), .seq_state_o(seq_state_o), .bit_ring_o(bit_ring_o)
);

// file: bench/dma_ch0_model.sv
// Behavioural DMA channel 0, fixed in write mode into the buffer.
// Assumes the request is a level held until acknowledged.
`timescale 1ns/1ps
module dma_ch0_model (
  input wire logic clk_i,       // System clock
  input wire logic rst_i,       // Synchronous reset
  input wire logic req_i,       // Channel 0 request
  input wire logic mute_i,      // Never answer
  input wire logic [7:0] dly_i, // Answer delay in cycles
  output logic ack_o            // Channel 0 acknowledge
);
  logic [7:0] cnt_q;
  // One-cycle acknowledge after the chosen delay, write transfers only
  always_ff @(posedge clk_i) begin
    if (rst_i || ack_o) begin
      ack_o <= 1'b0;
      cnt_q <= 8'h00;
    end else if (req_i && !mute_i) begin
      if (cnt_q + 8'h01 >= dly_i) ack_o <= 1'b1;
      else cnt_q <= cnt_q + 8'h01;
    end else begin
      cnt_q <= 8'h00;
    end
  end
endmodule : dma_ch0_model

// file: bench/tb_seq_setup_regs.sv
// Self-checking bench for the sequencer setup register block.
// Assumes the package, the design, the DMA model and the checker.
`timescale 1ns/1ps
module tb_seq_setup_regs;
  import seq_setup_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mute = 0;
  logic start = 0, tick = 0, idv = 0, dfd = 0, ovun = 0, perr = 0;
  logic [9:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] dat = '0, rd;
  logic [7:0] periph = 8'hC3, dly = 8'h02;
  id_header_t idh = '0;
  logic [31:0] dat_o;
  logic ack, strobe_n, req, dack, bwe, match, abort;
  logic [7:0] bdata, sval;
  logic [3:0] state, ring;
  int miscompares = 0, tests_run = 0, lows = 0;
  always #5 clk_i = ~clk_i;
  // Count cycles with the read strobe low
  always @(posedge clk_i) if (strobe_n === 1'b0) lows++;
  seq_setup_regs #(.DMA_TIMEOUT(8), .STROBE_LEN(2)) seq_setup_regs_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .periph_data_i(periph),
    .group_read_strobe_n_o(strobe_n), .dma_ch0_request_o(req),
    .dma_ch0_acknowledge_i(dack), .buf_we_o(bwe), .buf_data_o(bdata),
    .cmd_start_i(start), .byte_tick_i(tick), .id_valid_i(idv), .id_disk_i(idh),
    .data_field_done_i(dfd), .drive_ovun_i(ovun), .parity_err_i(perr),
    .id_match_o(match), .seq_state_o(state), .state_value_o(sval),
    .cmd_abort_o(abort), .bit_ring_o(ring));
  dma_ch0_model dma_ch0_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .mute_i(mute), .dly_i(dly), .ack_o(dack));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {1'b1, 1'b1, w, idx, 2'b00, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rd = dat_o;
    if (n >= 100) chk(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task rchk(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0);
    chk(rd & mask, exp);
  endtask : rchk
  task wait_bwe(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (bwe !== 1'b1 && n < 60);
    chk({24'h0, bdata}, {24'h0, exp});
  endtask : wait_bwe
  task idchk(input id_header_t h, input logic exp);
    @(posedge clk_i);
    {idh, idv} <= {h, 1'b1};
    @(posedge clk_i);
    idv <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({31'h0, match}, {31'h0, exp});
  endtask : idchk
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    logic [7:0] v[5] = '{8'h07, 8'h12, 8'h34, 8'h05, 8'h07};
    rchk(IDX_START_RESTART_STATE, 32'hFFFF_FFFF, 32'h33);
    rchk(IDX_LOOP_STATE_BANK, 32'hFFFF_FFFF, 32'h0E);
    rchk(IDX_BIT_RING_PARITY_CTL, 32'hFFFF_FFFF, 32'h03);
    wb(1'b1, IDX_LOOP_STATE_BANK, 32'h1E);
    rchk(IDX_LOOP_STATE_BANK, 32'hFF, 32'h1E);
    wb(1'b1, 8'hFF, 32'hA5);
    rchk(8'hFF, 32'hFFFF_FFFF, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'(IDX_SECTOR_MULTIPLIER + i), {24'h0, v[i]});
    end
    for (int i = 0; i < 5; i++) rchk(8'(IDX_SECTOR_MULTIPLIER + i), 32'hFF, {24'h0, v[i]});
    $display("test regs done");
  endtask : t_regs
  task t_ids;
    idchk({8'h12, 8'h34, 8'hA5, 8'h07}, 1'b1);
    wb(1'b1, IDX_CONFIG_CONTROL, 32'h04);
    idchk({8'h12, 8'h34, 8'hA5, 8'h07}, 1'b0);
    idchk({8'h12, 8'h34, 8'h05, 8'h07}, 1'b1);
    idchk({8'h12, 8'h35, 8'h05, 8'h07}, 1'b0);
    wb(1'b1, IDX_CONFIG_CONTROL, 32'h00);
    @(posedge clk_i);
    dfd <= 1'b1;
    @(posedge clk_i);
    dfd <= 1'b0;
    rchk(IDX_TARGET_SECTOR, 32'hFF, 32'h08);
    $display("test ids done");
  endtask : t_ids
  task t_port;
    wb(1'b1, IDX_BUFFER_BYTE_PORT, 32'h5A);
    wait_bwe(8'h5A);
    dly <= 8'h06;
    wb(1'b1, IDX_BUFFER_BYTE_PORT, 32'hA5);
    wait_bwe(8'hA5);
    rchk(IDX_EXTENDED_STATUS, 32'h03, 32'h0);
    mute <= 1'b1;
    wb(1'b1, IDX_BUFFER_BYTE_PORT, 32'h3C);
    repeat (20) @(posedge clk_i);
    rchk(IDX_SEQUENCER_STATUS, 32'h80, 32'h80);
    rchk(IDX_EXTENDED_STATUS, 32'h03, 32'h02);
    mute <= 1'b0;
    dly <= 8'h02;
    repeat (10) @(posedge clk_i);
    rchk(IDX_EXTENDED_STATUS, 32'h03, 32'h02);
    $display("test port done");
  endtask : t_port
  task t_periph;
    lows = 0;
    wb(1'b0, IDX_PERIPHERAL_FETCH_READ, 32'h0);
    repeat (10) @(posedge clk_i);
    chk(32'(lows), 32'h0);
    wb(1'b1, IDX_CRC_ECC_CONTROL, 32'h20);
    wb(1'b0, IDX_PERIPHERAL_FETCH_READ, 32'h0);
    wait_bwe(8'hC3);
    chk(32'(lows), 32'h2);
    wb(1'b1, IDX_CRC_ECC_CONTROL, 32'h00);
    $display("test periph done");
  endtask : t_periph
  task t_parity;
    wb(1'b1, IDX_BIT_RING_PARITY_CTL, 32'h13);
    @(posedge clk_i);
    ovun <= 1'b1;
    @(posedge clk_i);
    ovun <= 1'b0;
    rchk(IDX_EXTENDED_STATUS, 32'h03, 32'h01);
    @(posedge clk_i);
    perr <= 1'b1;
    @(posedge clk_i);
    perr <= 1'b0;
    rchk(IDX_EXTENDED_STATUS, 32'h03, 32'h02);
    wb(1'b1, IDX_BIT_RING_PARITY_CTL, 32'h03);
    $display("test parity done");
  endtask : t_parity
  task t_seq;
    logic [7:0] v[2] = '{8'h21, 8'h33};
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, IDX_START_RESTART_STATE, {24'h0, v[i]});
      @(posedge clk_i);
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({28'h0, state}, {28'h0, v[i][3:0]});
    end
    $display("test seq done");
  endtask : t_seq
  // Format RAM pair at the start state, sector size and abort
  task t_fmt;
    wb(1'b1, IDX_FMT_RAM_DATA, 32'h110);
    wb(1'b1, IDX_FMT_RAM_DATA, 32'h0A5);
    rchk(IDX_SECTOR_SIZE, 32'hFF, 32'h80);
    chk({24'h0, sval}, 32'hA5);
    wb(1'b1, IDX_BIT_RING_PARITY_CTL, 32'h43);
    @(posedge clk_i);
    ovun <= 1'b1;
    @(posedge clk_i);
    ovun <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, abort}, 32'h1);
    wb(1'b1, IDX_BIT_RING_PARITY_CTL, 32'h03);
    $display("test fmt done");
  endtask : t_fmt
  task wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_ids();
    t_port();
    t_periph();
    t_parity();
    t_seq();
    t_fmt();
    wrap_up();
  end
  // Watchdog well beyond the few hundred cycles needed
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule : tb_seq_setup_regs
